// ==== rtl/input_filter_edge_counter_map.svh ====
`ifndef INPUT_FILTER_EDGE_COUNTER_MAP_SVH
`define INPUT_FILTER_EDGE_COUNTER_MAP_SVH

// ============================================================
// Register numbers
`define REG_INPUT_STATE   8'h00
`define REG_EDGE_COUNT_1  8'h04
`define REG_EDGE_COUNT_2  8'h06
`define REG_EDGE_COUNT_3  8'h08
`define REG_EDGE_COUNT_4  8'h0A
`define REG_COUNT_CLEAR   8'h0C
`define REG_EDGE_SELECT   8'h0E
`define REG_FILTER_SET    8'h12

// ============================================================
// Field layout and limits
`define FALL_SEL_LSB      4
`define FILTER_OFF        8'h00
`define FILTER_MAX        8'hFA
`define FILTER_UNIT_US    100
`define SAMPLE_PERIOD_US  200
`define JITTER_MAX_US     50
`define CLK_FREQ_MHZ      10
`define SAMPLE_CYCLES     (`SAMPLE_PERIOD_US * `CLK_FREQ_MHZ)

`endif

// ==== rtl/input_filter_edge_counter_pkg.sv ====
package input_filter_edge_counter_pkg;

    // ============================================================
    // Cyclic snapshot delivered each network cycle
    typedef struct packed {
        logic [7:0]       input_state_byte;
        logic [3:0][15:0] edge_count;
    } cyclic_image_t;

    // ============================================================
    // Register access port
    typedef struct packed {
        logic       wr_en;
        logic       rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic        rvalid;
        logic [15:0] rdata;
    } reg_rsp_t;

endpackage : input_filter_edge_counter_pkg

// ==== rtl/input_filter_edge_counter.sv ====
// What this block does
// - One filter setting register applies to all four input channels together.
// - Each filter setting unit means 100 microseconds of input delay.
// - Inputs are sampled once every 200 microseconds; with setting zero they pass to the state every clock.
// - Setting zero disables filtering; settings above 250 clamp to 250.
// - Pulses shorter than the configured delay never change the reported state.
// - Filtering runs free of the network in 200 us steps, jitter within 50 us.
// - Input state is captured at the network cycle strobe and delivered that cycle.
// - Channels one to four appear in bits 0 to 3 of the state byte.
// - Counter mode gives four counters, each rising, falling or both edges.
// - Each counter is an unsigned 16-bit count of selected events.
// - Clear byte bits 0 to 3 clear counters one to four; zero does nothing.
// - A counter clears only on a 0-to-1 transition of its clear bit.
// - A clear bit held high does not stop later counting.
// - Edge select bits 0-3 enable rising, bits 4-7 falling, per channel.
`timescale 1ns/10ps
`include "input_filter_edge_counter_map.svh"

module input_filter_edge_counter
    import input_filter_edge_counter_pkg::*;
#(
    parameter int CHANNELS = 4
)
(
    input  wire logic                mclk_i,
    input  wire logic                rst_i,
    input  wire logic [CHANNELS-1:0] din_i,
    input  wire logic                counter_mode_i,
    input  wire logic                net_cycle_i,
    input  wire reg_req_t            reg_req_i,
    output reg_rsp_t                 reg_rsp_o,
    output cyclic_image_t            cyclic_o
);

    // ============================================================
    // State
    localparam int SAMPLE_CYC = `SAMPLE_CYCLES;
    localparam int TICK_W     = $clog2(SAMPLE_CYC);

    typedef struct packed {
        logic [CHANNELS-1:0]       sync1;
        logic [CHANNELS-1:0]       sync2;
        logic [CHANNELS-1:0]       filt;
        logic [7:0]                filter_cfg;
        logic [7:0]                edge_cfg;
        logic [7:0]                clear_byte;
        logic [7:0]                clear_prev;
        logic [TICK_W-1:0]         tick_cnt;
        logic [CHANNELS-1:0][7:0]  deb_cnt;
        logic [CHANNELS-1:0][15:0] count;
        cyclic_image_t             image;
        reg_rsp_t                  rsp;
    } state_t;

    state_t state_q;
    state_t state_d;

    // ============================================================
    // Helpers
    function automatic logic [7:0] clamp_filter(input logic [7:0] v);
        if (v > `FILTER_MAX)
        begin
            clamp_filter = `FILTER_MAX;
        end
        else
        begin
            clamp_filter = v;
        end
    endfunction : clamp_filter

    // Consecutive samples needed so that a pulse must last the full delay
    function automatic logic [7:0] needed_samples(input logic [7:0] cfg);
        logic [8:0] half;
        half           = ({1'b0, cfg} + 9'h001) >> 1;
        needed_samples = half[7:0] + 8'h01;
    endfunction : needed_samples

    function automatic logic is_count_reg(input logic [7:0] a);
        is_count_reg = (a == `REG_EDGE_COUNT_1) || (a == `REG_EDGE_COUNT_2) ||
                       (a == `REG_EDGE_COUNT_3) || (a == `REG_EDGE_COUNT_4);
    endfunction : is_count_reg

    function automatic logic [1:0] count_index(input logic [7:0] a);
        logic [7:0] rel;
        rel         = a - `REG_EDGE_COUNT_1;
        count_index = rel[2:1];
    endfunction : count_index

    // Read multiplexer for the register port
    function automatic logic [15:0] read_value(
        input logic [7:0]                addr,
        input logic [CHANNELS-1:0]       filt,
        input logic [CHANNELS-1:0][15:0] count
    );
        read_value = 16'h0000;
        if (addr == `REG_INPUT_STATE)
        begin
            read_value = {{(16-CHANNELS){1'b0}}, filt};
        end
        else if (is_count_reg(addr))
        begin
            read_value = count[count_index(addr)];
        end
    endfunction : read_value

    // ============================================================
    // Next state
    logic                tick;
    logic [7:0]          thr;
    logic [CHANNELS-1:0] filt_next;
    logic [CHANNELS-1:0] rise;
    logic [CHANNELS-1:0] fall;
    logic [CHANNELS-1:0] event_hit;
    logic [CHANNELS-1:0] clear_hit;

    always_comb
    begin
        state_d = state_q;
        tick    = (state_q.tick_cnt == TICK_W'(SAMPLE_CYC - 1));
        thr     = needed_samples(state_q.filter_cfg);

        // ============================================================
        // Two-flop input synchroniser
        state_d.sync1 = din_i;
        state_d.sync2 = state_q.sync1;

        // ============================================================
        // Free-running sample timer, independent of the network
        if (tick)
        begin
            state_d.tick_cnt = '0;
        end
        else
        begin
            state_d.tick_cnt = state_q.tick_cnt + TICK_W'(1);
        end

        // ============================================================
        // Debounce filter, one setting for every channel
        filt_next = state_q.filt;
        for (int i = 0; i < CHANNELS; i++)
        begin
            if (state_q.filter_cfg == `FILTER_OFF)
            begin
                filt_next[i]        = state_q.sync2[i];
                state_d.deb_cnt[i]  = '0;
            end
            else if (tick)
            begin
                if (state_q.sync2[i] != state_q.filt[i])
                begin
                    if (state_q.deb_cnt[i] + 8'h01 >= thr)
                    begin
                        filt_next[i]       = state_q.sync2[i];
                        state_d.deb_cnt[i] = '0;
                    end
                    else
                    begin
                        state_d.deb_cnt[i] = state_q.deb_cnt[i] + 8'h01;
                    end
                end
                else
                begin
                    state_d.deb_cnt[i] = '0;
                end
            end
        end
        state_d.filt = filt_next;

        // ============================================================
        // Edge counters on the filtered state
        rise      = filt_next & ~state_q.filt;
        fall      = ~filt_next & state_q.filt;
        event_hit = (rise & state_q.edge_cfg[CHANNELS-1:0]) |
                    (fall & state_q.edge_cfg[`FALL_SEL_LSB +: CHANNELS]);
        clear_hit = state_q.clear_byte[CHANNELS-1:0] &
                    ~state_q.clear_prev[CHANNELS-1:0];
        state_d.clear_prev = state_q.clear_byte;
        for (int i = 0; i < CHANNELS; i++)
        begin
            if (clear_hit[i])
            begin
                state_d.count[i] = {15'h0000, event_hit[i] & counter_mode_i};
            end
            else if (event_hit[i] && counter_mode_i)
            begin
                state_d.count[i] = state_q.count[i] + 16'h0001;
            end
        end

        // ============================================================
        // Cyclic image captured at the network cycle strobe
        if (net_cycle_i)
        begin
            state_d.image.input_state_byte = {{(8-CHANNELS){1'b0}}, state_q.filt};
            state_d.image.edge_count       = state_q.count;
        end

        // ============================================================
        // Register writes
        if (reg_req_i.wr_en)
        begin
            unique case (reg_req_i.addr)
                `REG_FILTER_SET:
                begin
                    state_d.filter_cfg = clamp_filter(reg_req_i.wdata);
                end
                `REG_EDGE_SELECT:
                begin
                    state_d.edge_cfg = reg_req_i.wdata;
                end
                `REG_COUNT_CLEAR:
                begin
                    state_d.clear_byte = reg_req_i.wdata;
                end
                default:
                begin
                end
            endcase
        end

        // ============================================================
        // Register reads, answered one cycle later
        state_d.rsp.rvalid = reg_req_i.rd_en;
        if (reg_req_i.rd_en)
        begin
            state_d.rsp.rdata = read_value(reg_req_i.addr, state_q.filt, state_q.count);
        end
        else
        begin
            state_d.rsp.rdata = 16'h0000;
        end
    end

    // ============================================================
    // Registers
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            state_q <= '0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // ============================================================
    // Outputs
    assign reg_rsp_o = state_q.rsp;
    assign cyclic_o  = state_q.image;

endmodule : input_filter_edge_counter

// ==== dv/input_filter_edge_counter_chk.sv ====
`timescale 1ns/10ps
`include "input_filter_edge_counter_map.svh"
module input_filter_edge_counter_chk
    import input_filter_edge_counter_pkg::*;
(
    input wire logic          mclk_i,
    input wire logic          rst_i,
    input wire logic          net_cycle_i,
    input wire reg_req_t      reg_req_i,
    input wire reg_rsp_t      reg_rsp_o,
    input wire cyclic_image_t cyclic_o
);
    // ============================================================
    // Port checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    a_read_answer: assert property (reg_req_i.rd_en |=> reg_rsp_o.rvalid)
        else $error("read unanswered");
    a_no_stray: assert property (!reg_req_i.rd_en |=> !reg_rsp_o.rvalid)
        else $error("stray rvalid");
    a_idle_zero: assert property (!reg_rsp_o.rvalid |-> reg_rsp_o.rdata == 16'h0000)
        else $error("idle rdata");
    a_state_upper: assert property (cyclic_o.input_state_byte[7:4] == 4'h0)
        else $error("state upper bits");
    a_state_read: assert property (reg_req_i.rd_en && reg_req_i.addr == `REG_INPUT_STATE |=>
        reg_rsp_o.rdata[15:4] == 12'h000) else $error("state read wide");
    a_image_holds: assert property (!net_cycle_i |=> $stable(cyclic_o))
        else $error("image moved");
    a_filter_hidden: assert property (reg_req_i.rd_en && reg_req_i.addr == `REG_FILTER_SET |=>
        reg_rsp_o.rdata == 16'h0000) else $error("filter readable");
    a_reset_clean: assert property ($fell(rst_i) |-> cyclic_o == '0)
        else $error("image after reset");
    c_read: cover property (reg_req_i.rd_en ##1 reg_rsp_o.rvalid);
    c_net: cover property (net_cycle_i ##1 cyclic_o.input_state_byte != 8'h00);
    c_clear: cover property (reg_req_i.wr_en && reg_req_i.addr == `REG_COUNT_CLEAR);
endmodule : input_filter_edge_counter_chk

// ==== dv/fieldbus_master_model.sv ====
`timescale 1ns/10ps
module fieldbus_master_model #(parameter int CYCLE_CLKS = 2000)
(
    input  wire logic mclk_i,
    input  wire logic rst_i,
    output logic      net_cycle_o
);
    int cnt_q;
    // ============================================================
    // Network cycle kept at 200 us so every cycle carries an update
    always_ff @(negedge mclk_i)
    begin
        cnt_q <= (rst_i || cnt_q == CYCLE_CLKS - 1) ? 0 : cnt_q + 1;
        net_cycle_o <= !rst_i && cnt_q == CYCLE_CLKS - 1;
    end
endmodule : fieldbus_master_model

// ==== dv/input_filter_edge_counter_bench.sv ====
`timescale 1ns/10ps
`include "input_filter_edge_counter_map.svh"
module input_filter_edge_counter_bench;
    import input_filter_edge_counter_pkg::*;
    logic          mclk_i = 0;
    logic          rst_i = 1;
    logic [3:0]    din_i = 0;
    logic          counter_mode_i = 1;
    logic          net_cycle_i;
    reg_req_t      reg_req_i = '0;
    reg_rsp_t      reg_rsp_o;
    cyclic_image_t cyclic_o;
    int            fails, compares, cycles, n;
    int            seed = 32'hc48b;
    logic [15:0]   expq[$];
    fieldbus_master_model u_master (.mclk_i, .rst_i, .net_cycle_o(net_cycle_i));
    input_filter_edge_counter u_dut (.mclk_i, .rst_i, .din_i, .counter_mode_i, .net_cycle_i,
        .reg_req_i, .reg_rsp_o, .cyclic_o);
    // ============================================================
    // Bus tasks and result checking
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk_i) reg_req_i <= '{1'b1, 1'b0, a, d};
        @(negedge mclk_i) reg_req_i <= '0;
        repeat (3) @(negedge mclk_i);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        expq.push_back(e);
        @(negedge mclk_i) reg_req_i <= '{1'b0, 1'b1, a, 8'h00};
        @(negedge mclk_i) reg_req_i <= '0;
        @(negedge mclk_i);
    endtask : rd
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e)
        begin
            fails++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic pulse(input int k, input int w);
        repeat (k)
        begin
            @(negedge mclk_i) din_i = 4'hF;
            repeat (w) @(negedge mclk_i);
            din_i = 4'h0;
            repeat (w) @(negedge mclk_i);
        end
    endtask : pulse
    task automatic results();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results
    always @(negedge mclk_i)
        if (reg_rsp_o.rvalid === 1'b1)
            chk(reg_rsp_o.rdata, expq.pop_front());
    always @(posedge mclk_i)
        if (++cycles == 40000)
        begin
            fails++;
            results();
        end
    initial
    begin
        forever #50 mclk_i = ~mclk_i;
    end
    // ============================================================
    // Scenarios
    initial
    begin
        repeat (4) @(negedge mclk_i);
        rst_i = 0;
        n = 1 + {$random(seed)} % 4;
        wr(`REG_FILTER_SET, `FILTER_OFF);
        wr(`REG_EDGE_SELECT, 8'h65);
        pulse(n, 6);
        rd(`REG_EDGE_COUNT_1, 16'(n));
        rd(`REG_EDGE_COUNT_2, 16'(n));
        rd(`REG_EDGE_COUNT_3, 16'(2 * n));
        rd(`REG_EDGE_COUNT_4, 16'h0000);
        rd(8'h01, 16'h0000);
        $display("edge test done");
        wr(`REG_COUNT_CLEAR, 8'h01);
        rd(`REG_EDGE_COUNT_1, 16'h0000);
        rd(`REG_EDGE_COUNT_2, 16'(n));
        pulse(2, 6);
        wr(`REG_COUNT_CLEAR, 8'h01);
        rd(`REG_EDGE_COUNT_1, 16'h0002);
        wr(`REG_COUNT_CLEAR, 8'h0E);
        rd(`REG_EDGE_COUNT_3, 16'h0000);
        rd(`REG_EDGE_COUNT_1, 16'h0002);
        counter_mode_i = 1'b0;
        pulse(1, 6);
        rd(`REG_EDGE_COUNT_1, 16'h0002);
        counter_mode_i = 1'b1;
        $display("clear test done");
        wr(`REG_FILTER_SET, 8'h04);
        pulse(1, 2500);
        rd(`REG_INPUT_STATE, 16'h0000);
        rd(`REG_EDGE_COUNT_1, 16'h0002);
        din_i = 4'hF;
        repeat (9000) @(negedge mclk_i);
        rd(`REG_INPUT_STATE, 16'h000F);
        rd(`REG_EDGE_COUNT_1, 16'h0003);
        chk(16'(cyclic_o.input_state_byte), 16'h000F);
        $display("filter test done");
        results();
    end
endmodule : input_filter_edge_counter_bench
bind input_filter_edge_counter input_filter_edge_counter_chk u_chk (.mclk_i, .rst_i,
    .net_cycle_i, .reg_req_i, .reg_rsp_o, .cyclic_o);
